// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import uecf_pkg::*;
;
  logic              clk, rst_n, psel, penable, pwrite, pslverr, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [6:0]        fclr, flags;
  uecf_sie_pkt_t     pkt;
  logic [6:0][4:0]   src;
  logic              pready;
  logic [7:0]        q;
  logic [23:0]       qh;
  logic [3:0]        pstrb;
  int                n_errors, compares, cyc;
  uecf_top DUT (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SIE_PKT(pkt), .EP_SOURCES(src), .FIFO_CLEAR(fclr),
    .EP_FLAGS(flags), .IRQ(irq)
  );
  uecf_sie_model sie (.clk(clk), .pkt(pkt), .src(src));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata[7:0];
    qh = prdata[31:8];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({23'h0, err, q}, {24'h0, e});
    chk({8'h0, qh}, 32'h0);
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_fifo;
    rd(12'h388, 8'h00);
    apb(1'b1, 12'h31C, 8'h02);
    apb(1'b1, 12'h354, 8'h7F);
    rd(12'h354, 8'h7F);
    chk({25'h0, fclr}, 32'h7F);
    sie.store(3'h2, 11'h105);
    rd(12'h388, 8'h00);
    apb(1'b1, 12'h354, 8'h00);
    sie.store(3'h2, 11'h105);
    rd(12'h388, 8'h05);
    chk({25'h0, fclr}, 32'h00);
  endtask
  task automatic t_count;
    logic [10:0] len [3] = '{11'h3FF, 11'h0FE, 11'h2A5};
    for (int i = 0; i < 3; i++) begin
      sie.store(3'(i * 3), len[i]);
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h31C, 8'(i * 3));
      rd(12'h388, len[i][7:0]);
      rd(12'h38C, {5'h0, len[i][10:8]});
    end
    sie.store(3'h3, 11'h011);
    apb(1'b1, 12'h31C, 8'h03);
    rd(12'h388, 8'h11);
    rd(12'h38C, 8'h00);
    sie.store(3'h3, 11'h5A0);
    rd(12'h388, 8'hFF);
    rd(12'h38C, 8'h03);
  endtask
  task automatic t_events;
    apb(1'b1, 12'h104, 8'h10);
    sie.set_src(4, 5'h04);
    repeat (3) @(posedge clk);
    rd(12'h3E0, 8'h10);
    chk({31'h0, irq}, 32'h1);
    sie.set_src(4, 5'h00);
    repeat (3) @(posedge clk);
    rd(12'h3E0, 8'h00);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h100, 8'h10);
    rd(12'h100, 8'h00);
    chk({31'h0, irq}, 32'h0);
    sie.set_src(1, 5'h10);
    repeat (3) @(posedge clk);
    rd(12'h100, 8'h02);
    chk({24'h0, flags, irq}, 32'h04);
    apb(1'b1, 12'h31C, 8'h01);
    rd(12'h31C, 8'h01);
    rd(12'h108, 8'h10);
    apb(1'b1, 12'h31C, 8'h07);
    rd(12'h388, 8'h00);
    rd(12'h108, 8'h00);
    // clear and new event on one edge, the event stays
    fork
      sie.set_src(2, 5'h01);
      apb(1'b1, 12'h100, 8'h04);
    join
    rd(12'h100, 8'h06);
    pstrb <= 4'h0;
    apb(1'b1, 12'h104, 8'h00);
    pstrb <= 4'hF;
    rd(12'h104, 8'h10);
    apb(1'b1, 12'h3E0, 8'h01);
    chk({31'h0, err}, 32'h0);
    rd(12'h3E0, 8'h06);
    apb(1'b0, 12'h000, 8'h00);
    chk({23'h0, err, q}, 32'h100);
    apb(1'b0, 12'h355, 8'h00);
    chk({23'h0, err, q}, 32'h100);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_fifo();
    t_count();
    t_events();
    test_done();
  end
endmodule

// *** bench/uecf_sie_model.sv ***
`timescale 1ns/1ps
module uecf_sie_model
  import uecf_pkg::*;
(
  input  wire logic            clk,
  output uecf_sie_pkt_t        pkt,
  output logic      [6:0][4:0] src
);
  initial begin
    pkt = '0;
    src = '0;
  end
  // one stored packet, fields scrambled once valid drops
  task automatic store(input logic [SEL_W-1:0] ep, input logic [LEN_W-1:0] len);
    @(posedge clk);
    pkt <= '{1'b1, ep, len};
    @(posedge clk);
    pkt <= '{1'b0, ~ep, ~len};
  endtask
  // level status sources of one endpoint
  task automatic set_src(input int e, input logic [4:0] v);
    @(posedge clk);
    src[e] <= v;
  endtask
endmodule

// *** bench/uecf_sva.sv ***
`timescale 1ns/1ps
module uecf_sva
  import uecf_pkg::*;
#(
  parameter int NUM_EP     = NUM_EP_DEF,
  parameter int SRC_PER_EP = SRC_PER_EP_DEF
) (
  input wire logic                              SYS_CLK,
  input wire logic                              RST_N,
  input wire logic                              PSEL,
  input wire logic                              PENABLE,
  input wire logic                              PWRITE,
  input wire logic [ADDR_W-1:0]                 PADDR,
  input wire logic [31:0]                       PRDATA,
  input wire logic                              PSLVERR,
  input wire logic [NUM_EP-1:0][SRC_PER_EP-1:0] EP_SOURCES,
  input wire logic [NUM_EP-1:0]                 FIFO_CLEAR,
  input wire logic [NUM_EP-1:0]                 EP_FLAGS,
  input wire logic                              IRQ
);
  logic [NUM_EP-1:0] any_src;
  logic              acc;
  logic              rd;
  logic              wr_fr;
  logic              irq_why;
  always_comb begin
    for (int e = 0; e < NUM_EP; e++) begin
      any_src[e] = |EP_SOURCES[e];
    end
  end
  assign acc   = PSEL && PENABLE;
  assign rd    = acc && !PWRITE;
  assign wr_fr = acc && PWRITE && PADDR == 12'h354;
  assign irq_why = |EP_FLAGS || (acc && PWRITE);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  flag_or_a: assert property ($past(RST_N) |-> EP_FLAGS == $past(any_src))
    else $error("flags not or of sources");
  fifo_hold_a: assert property (!$stable(FIFO_CLEAR) |-> $past(wr_fr))
    else $error("fifo clear moved without write");
  fifo_rsvd_a: assert property (rd && PADDR == 12'h354 |-> PRDATA[31:7] == 25'h0)
    else $error("fifo reset bit 7 set");
  high_rsvd_a: assert property (rd && PADDR == 12'h38C |-> PRDATA[31:2] == 30'h0)
    else $error("high count upper bits set");
  summary_read_a: assert property (rd && PADDR == 12'h3E0 |->
    PRDATA == {{(32-NUM_EP){1'b0}}, $past(EP_FLAGS)})
    else $error("summary differs from flags");
  unaligned_a: assert property (acc && PADDR[1:0] != 2'h0 |-> PSLVERR && PRDATA == 32'h0)
    else $error("unaligned access not refused");
  err_idle_a: assert property (!acc |-> !PSLVERR)
    else $error("error outside access");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(irq_why))
    else $error("irq rose without cause");
  c_irq_c: cover property ($rose(IRQ));
  c_clr_c: cover property ($rose(|FIFO_CLEAR));
  c_err_c: cover property (acc && PSLVERR);
endmodule
bind uecf_top uecf_sva #(.NUM_EP(NUM_EP), .SRC_PER_EP(SRC_PER_EP)) u_sva (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EP_SOURCES(EP_SOURCES),
  .FIFO_CLEAR(FIFO_CLEAR), .EP_FLAGS(EP_FLAGS), .IRQ(IRQ)
);

// *** src/uecf_apb_slave.sv ***
`timescale 1ns/1ps
module uecf_apb_slave
  import uecf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [IDX_W-1:0]  rd_idx,
  input  wire logic [REG_W-1:0]  rd_data,
  input  wire logic              rd_hit,
  output uecf_wr_t               wr
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } uecf_apb_state_t;

  uecf_apb_state_t st_reg;
  uecf_apb_state_t st_next;
  logic            good;

  assign rd_idx = paddr[ADDR_W-1:2];
  assign good   = rd_hit && (paddr[1:0] == 2'h0);

  // answer captured in setup, zero wait states in access
  always_comb begin
    st_next = st_reg;
    if (psel && !penable) begin
      st_next.rdata = good ? {24'h000000, rd_data} : 32'h00000000;
      st_next.err   = !good;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata  = st_reg.rdata;
  assign pslverr = st_reg.err && psel && penable;
  assign pready  = psel && penable;
  assign wr.en   = psel && penable && pwrite && !st_reg.err && pstrb[0];
  assign wr.idx  = rd_idx;
  assign wr.data = pwdata[REG_W-1:0];

endmodule

// *** src/uecf_ep_events.sv ***
`timescale 1ns/1ps
module uecf_ep_events
  import uecf_pkg::*;
#(
  parameter int NUM_EP     = NUM_EP_DEF,
  parameter int SRC_PER_EP = SRC_PER_EP_DEF
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic [NUM_EP-1:0][SRC_PER_EP-1:0]     sources,
  output logic      [NUM_EP-1:0]                     flags,
  output logic      [NUM_EP-1:0]                     rise
);

  typedef struct packed {
    logic [NUM_EP-1:0] flags;
    logic [NUM_EP-1:0] rise;
  } uecf_ev_state_t;

  uecf_ev_state_t    st_reg;
  uecf_ev_state_t    st_next;
  logic [NUM_EP-1:0] any_src;

  generate
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      assign any_src[e] = |sources[e];
    end
  endgenerate

  always_comb begin
    st_next       = st_reg;
    st_next.flags = any_src;
    st_next.rise  = any_src & ~st_reg.flags;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;
  assign rise  = st_reg.rise;

endmodule

// *** src/uecf_pkg.sv ***
package uecf_pkg;

  // geometry
  localparam int NUM_EP_DEF     = 7;
  localparam int SRC_PER_EP_DEF = 5;
  localparam int LEN_W          = 11;
  localparam int SEL_W          = 3;
  localparam int IDX_W          = 10;
  localparam int ADDR_W         = 12;
  localparam int REG_W          = 8;

  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_EP_SELECT   = 10'h0C7;
  localparam logic [IDX_W-1:0] IDX_FIFO_RESET  = 10'h0D5;
  localparam logic [IDX_W-1:0] IDX_CNT_LOW     = 10'h0E2;
  localparam logic [IDX_W-1:0] IDX_CNT_HIGH    = 10'h0E3;
  localparam logic [IDX_W-1:0] IDX_EP_SUMMARY  = 10'h0F8;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 10'h040;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 10'h041;
  localparam logic [IDX_W-1:0] IDX_EP_SOURCES  = 10'h042;

  // field positions
  localparam int CNT_LOW_LSB   = 0;
  localparam int CNT_LOW_W     = 8;
  localparam int CNT_HIGH_LSB  = 8;
  localparam int CNT_HIGH_W    = 3;

  // longest full-speed packet, keeps count bit 10 at zero
  localparam logic [LEN_W-1:0] MAX_PKT_LEN = 11'h3FF;

  // reset values
  localparam logic [SEL_W-1:0] RST_EP_SELECT  = 3'h0;
  localparam logic [REG_W-1:0] RST_FIFO_RESET = 8'h00;
  localparam logic [LEN_W-1:0] RST_CNT        = 11'h000;
  localparam logic [REG_W-1:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [REG_W-1:0] RST_IRQ_MASK   = 8'h00;

  // packet stored by the serial engine
  typedef struct packed {
    logic             valid;
    logic [SEL_W-1:0] ep;
    logic [LEN_W-1:0] length;
  } uecf_sie_pkt_t;

  // register write strobe
  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] data;
  } uecf_wr_t;

endpackage

// *** src/uecf_top.sv ***
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Count low returns bits 7 to 0 of the last received length, saturated at 1023, of the selected endpoint.
// - Count high returns bits 10 to 8 of that saturated length in its bits 2 to 0 for the selected endpoint.
// - High count bits 7 to 2 read as zero and firmware never writes ones there.
// - A FIFO stays in reset while its bit is set and is usable once firmware clears it.
// - Bit 7 of the FIFO reset register is reserved, reads zero and is never set by firmware.
// - The endpoint summary is read-only, one flag per endpoint in bits 6 to 0, bit 7 zero.
// - An endpoint flag sets when any of its sources is active and clears when all are clear.
module uecf_top
  import uecf_pkg::*;
#(
  parameter int NUM_EP     = NUM_EP_DEF,
  parameter int SRC_PER_EP = SRC_PER_EP_DEF
) (
  input  wire logic                              SYS_CLK,
  input  wire logic                              RST_N,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [ADDR_W-1:0]                 PADDR,
  input  wire logic [31:0]                       PWDATA,
  input  wire logic [3:0]                        PSTRB,
  output logic      [31:0]                       PRDATA,
  output logic                                   PREADY,
  output logic                                   PSLVERR,
  input  uecf_sie_pkt_t                          SIE_PKT,
  input  wire logic [NUM_EP-1:0][SRC_PER_EP-1:0] EP_SOURCES,
  output logic      [NUM_EP-1:0]                 FIFO_CLEAR,
  output logic      [NUM_EP-1:0]                 EP_FLAGS,
  output logic                                   IRQ
);

  generate
    if (NUM_EP < 1 || NUM_EP > 7) begin : g_chk_ep
      $error("NUM_EP must be 1 to 7");
    end
    if (SRC_PER_EP < 1) begin : g_chk_src
      $error("SRC_PER_EP must be at least 1");
    end
  endgenerate

  localparam logic [SEL_W-1:0] LAST_EP = SEL_W'(NUM_EP - 1);

  typedef struct packed {
    logic [SEL_W-1:0]             select;
    logic [NUM_EP-1:0]            fifo_rst;
    logic [NUM_EP-1:0][LEN_W-1:0] counts;
    logic [NUM_EP-1:0]            irq_stat;
    logic [NUM_EP-1:0]            irq_mask;
  } uecf_state_t;

  uecf_state_t       st_reg;
  uecf_state_t       st_next;
  uecf_wr_t          wr;
  logic [IDX_W-1:0]  rd_idx;
  logic [REG_W-1:0]  rd_data;
  logic              rd_hit;
  logic [NUM_EP-1:0] ev_rise;
  logic [NUM_EP-1:0] ev_flags;
  logic [LEN_W-1:0]  sel_count;
  logic [LEN_W-1:0]  pkt_len;
  logic [NUM_EP-1:0] src_sel;

  uecf_apb_slave u_apb (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .pstrb   (PSTRB),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_hit  (rd_hit),
    .wr      (wr)
  );

  uecf_ep_events #(
    .NUM_EP     (NUM_EP),
    .SRC_PER_EP (SRC_PER_EP)
  ) u_events (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .sources (EP_SOURCES),
    .flags   (ev_flags),
    .rise    (ev_rise)
  );

  // count of the selected endpoint, zero past the last one
  always_comb begin
    sel_count = RST_CNT;
    if (st_reg.select <= LAST_EP) begin
      sel_count = st_reg.counts[st_reg.select];
    end
  end

  // status sources of the selected endpoint
  always_comb begin
    src_sel = '0;
    if (st_reg.select <= LAST_EP && SRC_PER_EP <= NUM_EP) begin
      src_sel[SRC_PER_EP-1:0] = EP_SOURCES[st_reg.select];
    end
  end

  // full-speed lengths never pass 1023
  assign pkt_len = (SIE_PKT.length > MAX_PKT_LEN) ? MAX_PKT_LEN : SIE_PKT.length;

  // read decode
  always_comb begin
    rd_data = 8'h00;
    rd_hit  = 1'b1;
    case (rd_idx)
      IDX_EP_SELECT: begin
        rd_data = {5'h00, st_reg.select};
      end
      IDX_FIFO_RESET: begin
        rd_data = {{(REG_W-NUM_EP){1'b0}}, st_reg.fifo_rst};
      end
      IDX_CNT_LOW: begin
        rd_data = sel_count[CNT_LOW_LSB +: CNT_LOW_W];
      end
      IDX_CNT_HIGH: begin
        rd_data = {5'h00, sel_count[CNT_HIGH_LSB +: CNT_HIGH_W]};
      end
      IDX_EP_SUMMARY: begin
        rd_data = {{(REG_W-NUM_EP){1'b0}}, ev_flags};
      end
      IDX_IRQ_STATUS: begin
        rd_data = {{(REG_W-NUM_EP){1'b0}}, st_reg.irq_stat};
      end
      IDX_IRQ_MASK: begin
        rd_data = {{(REG_W-NUM_EP){1'b0}}, st_reg.irq_mask};
      end
      IDX_EP_SOURCES: begin
        rd_data = {{(REG_W-NUM_EP){1'b0}}, src_sel};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (wr.en) begin
      case (wr.idx)
        IDX_EP_SELECT: begin
          st_next.select = wr.data[SEL_W-1:0];
        end
        IDX_FIFO_RESET: begin
          st_next.fifo_rst = wr.data[NUM_EP-1:0];
        end
        IDX_IRQ_MASK: begin
          st_next.irq_mask = wr.data[NUM_EP-1:0];
        end
        IDX_IRQ_STATUS: begin
          st_next.irq_stat = st_reg.irq_stat & ~wr.data[NUM_EP-1:0];
        end
        default: begin
          st_next.select = st_reg.select; // count and summary writes ignored
        end
      endcase
    end
    // new event beats a clear in the same cycle
    st_next.irq_stat = st_next.irq_stat | ev_rise;
    if (SIE_PKT.valid && SIE_PKT.ep <= LAST_EP && !st_reg.fifo_rst[SIE_PKT.ep]) begin
      st_next.counts[SIE_PKT.ep] = pkt_len;
    end
    for (int e = 0; e < NUM_EP; e++) begin
      if (st_reg.fifo_rst[e]) begin
        st_next.counts[e] = RST_CNT;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg.select   <= RST_EP_SELECT;
      st_reg.fifo_rst <= RST_FIFO_RESET[NUM_EP-1:0];
      st_reg.counts   <= {NUM_EP{RST_CNT}};
      st_reg.irq_stat <= RST_IRQ_STATUS[NUM_EP-1:0];
      st_reg.irq_mask <= RST_IRQ_MASK[NUM_EP-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign FIFO_CLEAR = st_reg.fifo_rst;
  assign EP_FLAGS   = ev_flags;
  assign IRQ        = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule
